// ### spdio_pkg.sv
/*
  Constants and carrier types for the seven-point direct I/O logic.
  Assumes a single 200 MHz clock and a motion core outside that reports position and status.
*/
// Summary of operation
// (RULE_01) A rising edge on one of the seven point-start inputs starts a move to point 0 to 6.
// (RULE_02) Each of the seven arrival outputs turns on when a move to its own point finishes.
// (RULE_03) The brake-release input forces the brake open whatever the other inputs do.
// (RULE_04) The mode input selects automatic or manual operation.
// (RULE_05) The manual-mode flag is low in automatic mode and high in manual mode.
// (RULE_06) A rising edge on the homing input starts a home return.
// (RULE_07) Pause is active low: high permits motion, low makes the actuator decelerate to a stop.
// (RULE_08) A rising edge on the alarm-clear input clears the active alarm.
// (RULE_09) The servo is energised exactly while the servo-on input is high.
// (RULE_10) The parameter zone flag is valid only after homing and is on while inside the range.
// (RULE_11) The table zone flag is valid only after a move command and is on while in range.
// (RULE_12) Homing-done is low after power-up and goes high once a home return finishes.
// (RULE_13) Positioning-done is high with no estop, drive power and servo on, and pause high; the code also requires state SPDIO_IDLE.
// (RULE_14) The drive-ready output is high while the servo is on and the controller can operate.
// (RULE_15) The estop status output is active low and is low while an emergency stop is in effect.
// (RULE_16) The fault output is active low: high in normal use, low while an alarm stands.
// (RULE_17) Host inputs pass a two-stage synchroniser; edges compare with the prior sample.
package spdio_pkg;

  localparam int unsigned NUM_POINTS = 7;
  localparam int unsigned POS_W      = 16;
  localparam int unsigned PT_W       = 3;
  localparam int unsigned NUM_IN     = 13;

  localparam logic [PT_W-1:0]  POINT_NONE  = 3'h7;
  localparam logic [POS_W-1:0] POS_RESET   = 16'h0000;

  // Host input vector bit positions
  localparam int unsigned IN_GOTO0  = 0;
  localparam int unsigned IN_HOME   = 7;
  localparam int unsigned IN_BRAKE  = 8;
  localparam int unsigned IN_MODE   = 9;
  localparam int unsigned IN_PAUSE  = 10;
  localparam int unsigned IN_CLEAR  = 11;
  localparam int unsigned IN_SERVO  = 12;

  typedef enum logic [1:0] {
    SPDIO_IDLE,
    SPDIO_MOVE,
    SPDIO_HOMING
  } spdio_state_t;

  typedef struct packed {
    logic [NUM_POINTS-1:0] goto_point;
    logic                  homing;
    logic                  brake_force_open;
    logic                  manual_mode;
    logic                  pause_n;
    logic                  alarm_clear;
    logic                  servo_on_request;
  } spdio_host_in_t;

  typedef struct packed {
    logic             start;
    logic             home;
    logic [PT_W-1:0]  point;
    logic             run;
  } spdio_motion_cmd_t;

  typedef struct packed {
    logic             move_done;
    logic             home_done;
    logic             fault;
    logic             estop;
    logic             drive_power;
    logic [POS_W-1:0] position;
  } spdio_motion_sts_t;

endpackage

// ### spdio_sync.sv
/*
  Two-stage synchroniser with registered rising-edge detect for a vector of host inputs.
  Assumes the inputs are static discrete levels from a PLC.
*/
`timescale 1ns/1ps
module spdio_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // ----------------------------------------------------------------
  // Synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= async_in; // RULE_17
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg; // RULE_17

endmodule

// ### spdio_top.sv
/*
  Seven-point direct-command discrete I/O logic of a positioner controller.
  Assumes an external motion core that executes moves and homing and reports position and status.
*/
`timescale 1ns/1ps
module spdio_top (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire spdio_pkg::spdio_host_in_t       host_in,
  input  wire spdio_pkg::spdio_motion_sts_t    motion_sts,
  input  wire logic [spdio_pkg::POS_W-1:0]     param_zone_lo,
  input  wire logic [spdio_pkg::POS_W-1:0]     param_zone_hi,
  input  wire logic [spdio_pkg::POS_W-1:0]     table_zone_lo [spdio_pkg::NUM_POINTS],
  input  wire logic [spdio_pkg::POS_W-1:0]     table_zone_hi [spdio_pkg::NUM_POINTS],
  output spdio_pkg::spdio_motion_cmd_t         motion_cmd,
  output logic                                 servo_enable,
  output logic                                 brake_open,
  output logic [spdio_pkg::NUM_POINTS-1:0]     arrived_point,
  output logic                                 param_range_flag,
  output logic                                 table_range_flag,
  output logic                                 manual_mode_flag,
  output logic                                 homing_done,
  output logic                                 positioning_done,
  output logic                                 drive_ready,
  output logic                                 estop_status_n,
  output logic                                 fault_n
);

  localparam int unsigned NP = spdio_pkg::NUM_POINTS;
  localparam int unsigned PW = spdio_pkg::POS_W;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [spdio_pkg::NUM_IN-1:0] raw_in;
  logic [spdio_pkg::NUM_IN-1:0] lvl;
  logic [spdio_pkg::NUM_IN-1:0] rise;

  assign raw_in = {host_in.servo_on_request, host_in.alarm_clear, host_in.pause_n,
                   host_in.manual_mode, host_in.brake_force_open, host_in.homing,
                   host_in.goto_point};

  spdio_sync #(
    .W (spdio_pkg::NUM_IN)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .level    (lvl),
    .rise     (rise)
  );

  logic [NP-1:0] goto_rise;
  logic          home_rise;
  logic          clear_rise;
  logic          pause_ok;
  logic          manual_lvl;
  logic          servo_lvl;
  logic          brake_lvl;

  assign goto_rise  = rise[spdio_pkg::IN_GOTO0 +: NP];
  assign home_rise  = rise[spdio_pkg::IN_HOME];
  assign clear_rise = rise[spdio_pkg::IN_CLEAR];
  assign pause_ok   = lvl[spdio_pkg::IN_PAUSE];
  assign manual_lvl = lvl[spdio_pkg::IN_MODE];
  assign servo_lvl  = lvl[spdio_pkg::IN_SERVO];
  assign brake_lvl  = lvl[spdio_pkg::IN_BRAKE];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest set bit to point number; POINT_NONE when empty
  function automatic logic [spdio_pkg::PT_W-1:0] first_point(input logic [NP-1:0] v);
    logic [spdio_pkg::PT_W-1:0] r;
    r = spdio_pkg::POINT_NONE;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = spdio_pkg::PT_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [PW-1:0] p,
                                    input logic [PW-1:0] lo,
                                    input logic [PW-1:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Status, alarm and readiness
  // ----------------------------------------------------------------
  logic alarm_reg;
  logic can_operate;
  logic servo_reg;

  // Fault stays latched until a clear edge; a new fault in the clear cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
    end else if (motion_sts.fault) begin
      alarm_reg <= 1'b1; // RULE_16
    end else if (clear_rise) begin
      alarm_reg <= 1'b0; // RULE_08
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_reg <= 1'b0;
    end else begin
      servo_reg <= servo_lvl; // RULE_09
    end
  end

  assign can_operate = servo_reg && !alarm_reg && !motion_sts.estop && motion_sts.drive_power;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  spdio_pkg::spdio_state_t state_reg;
  logic [spdio_pkg::PT_W-1:0] target_reg;
  logic [spdio_pkg::PT_W-1:0] req_point;
  logic start_ok;
  logic start_reg;
  logic home_reg;
  logic homed_reg;
  logic cmd_seen_reg;
  logic [NP-1:0] arrived_reg;

  assign req_point = first_point(goto_rise);
  // Commands are refused in manual mode, while paused or not able to operate
  assign start_ok  = can_operate && pause_ok && !manual_lvl; // RULE_04

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= spdio_pkg::SPDIO_IDLE;
      target_reg <= spdio_pkg::POINT_NONE;
      start_reg  <= 1'b0;
      home_reg   <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      home_reg  <= 1'b0;
      unique case (state_reg)
        spdio_pkg::SPDIO_IDLE: begin
          if (start_ok && home_rise) begin
            home_reg  <= 1'b1; // RULE_06
            state_reg <= spdio_pkg::SPDIO_HOMING;
          end else if (start_ok && req_point != spdio_pkg::POINT_NONE) begin
            start_reg  <= 1'b1; // RULE_01
            target_reg <= req_point;
            state_reg  <= spdio_pkg::SPDIO_MOVE;
          end
        end
        spdio_pkg::SPDIO_MOVE: begin
          if (motion_sts.move_done || !can_operate) begin
            state_reg <= spdio_pkg::SPDIO_IDLE;
          end
        end
        spdio_pkg::SPDIO_HOMING: begin
          if (motion_sts.home_done || !can_operate) begin
            state_reg <= spdio_pkg::SPDIO_IDLE;
          end
        end
      endcase
    end
  end

  // Homing status and first-command tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      homed_reg    <= 1'b0;
      cmd_seen_reg <= 1'b0;
    end else begin
      if (state_reg == spdio_pkg::SPDIO_HOMING && motion_sts.home_done) begin
        homed_reg <= 1'b1; // RULE_12
      end else if (home_reg) begin
        homed_reg <= 1'b0;
      end
      if (start_reg) begin
        cmd_seen_reg <= 1'b1; // RULE_11
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-point arrival
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_arrive
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          arrived_reg[g] <= 1'b0;
        end else if (start_reg || home_reg) begin
          arrived_reg[g] <= 1'b0;
        end else if (state_reg == spdio_pkg::SPDIO_MOVE && motion_sts.move_done
                     && target_reg == spdio_pkg::PT_W'(g)) begin
          arrived_reg[g] <= 1'b1; // RULE_02
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Zone flags
  // ----------------------------------------------------------------
  logic table_range_flag_reg;
  logic tzone_reg;
  logic [PW-1:0] tlo;
  logic [PW-1:0] thi;

  assign tlo = (target_reg < spdio_pkg::PT_W'(NP)) ? table_zone_lo[target_reg] : '0;
  assign thi = (target_reg < spdio_pkg::PT_W'(NP)) ? table_zone_hi[target_reg] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_range_flag_reg <= 1'b0;
      tzone_reg <= 1'b0;
    end else begin
      table_range_flag_reg <= homed_reg && in_range(motion_sts.position, param_zone_lo,
                                          param_zone_hi); // RULE_10
      tzone_reg <= cmd_seen_reg && in_range(motion_sts.position, tlo, thi); // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic positioning_done_reg;
  logic ready_reg;
  logic estop_reg;
  logic brake_reg;
  logic manual_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      positioning_done_reg   <= 1'b0;
      ready_reg  <= 1'b0;
      estop_reg  <= 1'b0;
      brake_reg  <= 1'b0;
      manual_reg <= 1'b0;
    end else begin
      positioning_done_reg   <= !motion_sts.estop && motion_sts.drive_power && servo_reg
                    && pause_ok && state_reg == spdio_pkg::SPDIO_IDLE; // RULE_13
      ready_reg  <= can_operate; // RULE_14
      estop_reg  <= motion_sts.estop; // RULE_15
      brake_reg  <= brake_lvl || servo_reg; // RULE_03
      manual_reg <= manual_lvl; // RULE_05
    end
  end

  assign motion_cmd.start = start_reg;
  assign motion_cmd.home  = home_reg;
  assign motion_cmd.point = target_reg;
  assign motion_cmd.run   = pause_ok && can_operate; // RULE_07

  assign servo_enable     = servo_reg;
  assign brake_open       = brake_reg;
  assign arrived_point    = arrived_reg;
  assign param_range_flag = table_range_flag_reg;
  assign table_range_flag = tzone_reg;
  assign manual_mode_flag = manual_reg;
  assign homing_done      = homed_reg;
  assign positioning_done = positioning_done_reg;
  assign drive_ready      = ready_reg;
  assign estop_status_n   = !estop_reg;
  assign fault_n          = !alarm_reg;

endmodule

// ### spdio_motion_model.sv
/*
  Behavioural motion core facing the seven-point direct I/O logic.
  Assumes the bench drives fault and estop levels; drive power is always present.
*/
`timescale 1ns/1ps
module spdio_motion_model #(
  parameter logic [15:0] STEP = 16'h0040
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire spdio_pkg::spdio_motion_cmd_t  cmd,
  input  wire logic                          fault_in,
  input  wire logic                          estop_in,
  output spdio_pkg::spdio_motion_sts_t       sts
);
  logic [15:0] pos_reg;
  logic [15:0] tgt_reg;
  logic        busy_reg;
  logic        home_reg;
  logic        done_reg;
  logic        hdone_reg;

  // ----------------------------------------
  // Target point n sits at (n+1) * 256
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 16'h0000;
      tgt_reg <= 16'h0000;
      busy_reg <= 1'b0;
      home_reg <= 1'b0;
      done_reg <= 1'b0;
      hdone_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      hdone_reg <= 1'b0;
      if (cmd.start || cmd.home) begin
        busy_reg <= 1'b1;
        home_reg <= cmd.home;
        tgt_reg <= cmd.home ? 16'h0000 : {5'h00, cmd.point, 8'h00} + 16'h0100;
      end else if (busy_reg && cmd.run) begin
        if (pos_reg == tgt_reg) begin
          busy_reg <= 1'b0;
          done_reg <= !home_reg;
          hdone_reg <= home_reg;
        end else if (pos_reg < tgt_reg) begin
          pos_reg <= pos_reg + STEP;
        end else begin
          pos_reg <= pos_reg - STEP;
        end
      end
    end
  end

  assign sts = '{move_done: done_reg, home_done: hdone_reg, fault: fault_in,
                 estop: estop_in, drive_power: 1'b1, position: pos_reg};
endmodule

// ### spdio_checker.sv
/*
  Port-level assertions for spdio_top.
  Assumes it is bound to the top module with the top's port names.
*/
`timescale 1ns/1ps
module spdio_checker (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire spdio_pkg::spdio_host_in_t    host_in,
  input wire spdio_pkg::spdio_motion_sts_t motion_sts,
  input wire logic [15:0]                  param_zone_lo,
  input wire logic [15:0]                  param_zone_hi,
  input wire spdio_pkg::spdio_motion_cmd_t motion_cmd,
  input wire logic                         servo_enable,
  input wire logic                         brake_open,
  input wire logic [6:0]                   arrived_point,
  input wire logic                         param_range_flag,
  input wire logic                         manual_mode_flag,
  input wire logic                         homing_done,
  input wire logic                         estop_status_n,
  input wire logic                         fault_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  servo_follow_a: assert property ($rose(host_in.servo_on_request)
      |-> ##[2:4] servo_enable)
    else $error("servo enable late");
  brake_force_a: assert property ($rose(host_in.brake_force_open)
      |-> ##[2:4] brake_open)
    else $error("brake not opened");
  manual_on_a: assert property (host_in.manual_mode [*5] |-> manual_mode_flag)
    else $error("manual flag low");
  auto_off_a: assert property (!host_in.manual_mode [*5] |-> !manual_mode_flag)
    else $error("manual flag high");
  estop_mirror_a: assert property (1'b1 |=> estop_status_n == !$past(motion_sts.estop))
    else $error("estop status wrong");
  fault_set_a: assert property (motion_sts.fault |=> !fault_n)
    else $error("fault not flagged");
  pause_stop_a: assert property (!host_in.pause_n [*4] |-> !motion_cmd.run)
    else $error("run while paused");
  arrive_cause_a: assert property (|(arrived_point & ~$past(arrived_point))
      |-> $past(motion_sts.move_done))
    else $error("arrival without done");
  home_cause_a: assert property ($rose(homing_done) |-> $past(motion_sts.home_done))
    else $error("homed without done");
  start_pulse_a: assert property (motion_cmd.start |->
      !motion_cmd.home ##1 !motion_cmd.start)
    else $error("start not a pulse");
  param_zone_a: assert property (param_range_flag |->
      $past(motion_sts.position) >= $past(param_zone_lo)
      && $past(motion_sts.position) <= $past(param_zone_hi))
    else $error("zone flag outside range");

  cover property (motion_cmd.start);
  cover property (motion_cmd.home);
  cover property (!fault_n);
endmodule

bind spdio_top spdio_checker chk (.clk(clk), .rst_n(rst_n), .host_in(host_in),
  .motion_sts(motion_sts), .param_zone_lo(param_zone_lo), .param_zone_hi(param_zone_hi),
  .motion_cmd(motion_cmd), .servo_enable(servo_enable), .brake_open(brake_open),
  .arrived_point(arrived_point), .param_range_flag(param_range_flag),
  .manual_mode_flag(manual_mode_flag), .homing_done(homing_done),
  .estop_status_n(estop_status_n), .fault_n(fault_n));

// ### test_seven_point_direct_io.sv
/*
  Self-checking bench for spdio_top with a behavioural motion core.
  Assumes host bits: goto 12:6, home 5, brake 4, mode 3, pause 2, clear 1, servo 0.
*/
`timescale 1ns/1ps
module test_seven_point_direct_io;
  logic                          clk;
  logic                          rst_n;
  spdio_pkg::spdio_host_in_t     hi;
  spdio_pkg::spdio_motion_sts_t  sts;
  spdio_pkg::spdio_motion_cmd_t  cmd;
  logic [15:0]                   tlo [7];
  logic [15:0]                   thi [7];
  logic                          flt;
  logic                          est;
  logic                          srv;
  logic                          brk;
  logic [6:0]                    arr;
  logic                          pzf;
  logic                          tzf;
  logic                          mmf;
  logic                          hdn;
  logic                          pdn;
  logic                          rdy;
  logic                          esn;
  logic                          fln;
  int                            fails;
  int                            checked;

  spdio_top uut (.clk(clk), .rst_n(rst_n), .host_in(hi), .motion_sts(sts),
    .param_zone_lo(16'h0000), .param_zone_hi(16'h0080), .table_zone_lo(tlo),
    .table_zone_hi(thi), .motion_cmd(cmd), .servo_enable(srv), .brake_open(brk),
    .arrived_point(arr), .param_range_flag(pzf), .table_range_flag(tzf),
    .manual_mode_flag(mmf), .homing_done(hdn), .positioning_done(pdn),
    .drive_ready(rdy), .estop_status_n(esn), .fault_n(fln));
  spdio_motion_model core (.clk(clk), .rst_n(rst_n), .cmd(cmd), .fault_in(flt),
    .estop_in(est), .sts(sts));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int b);
    hi[b] = 1'b1;
    cyc(6);
    hi[b] = 1'b0;
    cyc(2);
  endtask
  task automatic wait_arr(input logic [6:0] e);
    for (int k = 0; k < 300 && arr !== e; k++) cyc(1);
  endtask

  task automatic t_reset;
    chk("homing_done", 1'b0, hdn);
    chk("fault_n", 1'b1, fln);
    chk("estop_status_n", 1'b1, esn);
    chk("drive_ready", 1'b0, rdy);
    chk("param_range_flag", 1'b0, pzf);
    chk("table_range_flag", 1'b0, tzf);
    $display("test reset done");
  endtask
  task automatic t_brake;
    hi.brake_force_open = 1'b1;
    cyc(6);
    chk("brake_open", 1'b1, brk);
    hi.brake_force_open = 1'b0;
    cyc(6);
    chk("brake_open", 1'b0, brk);
    $display("test brake done");
  endtask
  task automatic t_servo;
    hi.servo_on_request = 1'b1;
    cyc(6);
    chk("servo_enable", 1'b1, srv);
    chk("drive_ready", 1'b1, rdy);
    chk("positioning_done", 1'b1, pdn);
    $display("test servo done");
  endtask
  task automatic t_mode;
    hi.manual_mode = 1'b1;
    cyc(6);
    chk("manual_mode_flag", 1'b1, mmf);
    pulse(6);
    cyc(10);
    chk("arrived_point", 7'h00, arr);
    hi.manual_mode = 1'b0;
    cyc(6);
    chk("manual_mode_flag", 1'b0, mmf);
    $display("test mode done");
  endtask
  task automatic t_home;
    pulse(5);
    for (int k = 0; k < 100 && hdn !== 1'b1; k++) cyc(1);
    cyc(2);
    chk("homing_done", 1'b1, hdn);
    chk("param_range_flag", 1'b1, pzf);
    $display("test home done");
  endtask
  task automatic t_points;
    for (int i = 0; i < 7; i++) begin
      pulse(6 + i);
      wait_arr(7'h01 << i);
      cyc(2);
      chk("arrived_point", 7'h01 << i, arr);
      chk("point", 16'(i), cmd.point);
      chk("table_range_flag", 1'b1, tzf);
      chk("param_range_flag", 1'b0, pzf);
    end
    $display("test points done");
  endtask
  task automatic t_pause;
    hi.goto_point = 7'h01;
    cyc(8);
    hi.pause_n = 1'b0;
    cyc(6);
    chk("run", 1'b0, cmd.run);
    cyc(20);
    chk("arrived_point", 7'h00, arr);
    hi.pause_n = 1'b1;
    hi.goto_point = 7'h00;
    wait_arr(7'h01);
    chk("arrived_point", 7'h01, arr);
    $display("test pause done");
  endtask
  task automatic t_alarm;
    flt = 1'b1;
    cyc(4);
    chk("fault_n", 1'b0, fln);
    chk("drive_ready", 1'b0, rdy);
    flt = 1'b0;
    cyc(3);
    chk("fault_n", 1'b0, fln);
    pulse(1);
    chk("fault_n", 1'b1, fln);
    est = 1'b1;
    cyc(4);
    chk("estop_status_n", 1'b0, esn);
    chk("positioning_done", 1'b0, pdn);
    est = 1'b0;
    cyc(4);
    chk("estop_status_n", 1'b1, esn);
    chk("positioning_done", 1'b1, pdn);
    $display("test alarm done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    hi = '0;
    hi.pause_n = 1'b1;
    flt = 1'b0;
    est = 1'b0;
    fails = 0;
    checked = 0;
    for (int i = 0; i < 7; i++) begin
      thi[i] = {5'h00, 3'(i), 8'h00} + 16'h0100;
      tlo[i] = thi[i] - 16'h0040;
    end
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    t_reset();
    t_brake();
    t_servo();
    t_mode();
    t_home();
    t_points();
    t_pause();
    t_alarm();
    end_of_test();
  end
endmodule
